//--- include/ledsc_pkg.sv
// Functional notes
// RL1: In operation, over-temperature or gate-driver fault moves the device to fail-silent.
// RL2: Fail-silent holds every output off; serial interface still reads and writes.
// RL3: Per channel, switch off above upper threshold, back on below lower threshold.
// RL4: Supply code readable at 0x38; zero means no measurement available.
// RL5: A write to the supply measurement register never raises the error flag.
// RL6: Above-undervoltage flag high while supply above threshold, low while below.
// RL7: Undervoltage threshold is an 8-bit code at 0x0F; zero means 0 V.
// RL8: Register 0x05 bits 0..2 pick the current range of channels 1..3.
// RL9: Host writes zeros to range register bits 7:3 and keeps them clear.
// RL10: Registers 0x02..0x04 hold the 8-bit target level of channels 1..3.
// RL11: A set range bit selects the fine scale for that channel's target level.
// RL12: Host should prefer the fine range when the wanted current fits.
// RL13: Enable low or supply below power-off level gives off mode, interface disabled.
// RL14: Supply under programmed threshold moves operation to undervoltage, outputs off.
// RL15: Flag updates on each new measurement by comparing code with threshold code.
package ledsc_pkg;
   localparam int NUM_CH = 3;
   localparam int ADDR_W = 7;
   localparam logic [6:0] ADDR_CH1 = 7'h02;
   localparam logic [6:0] ADDR_CH2 = 7'h03;
   localparam logic [6:0] ADDR_CH3 = 7'h04;
   localparam logic [6:0] ADDR_RANGE = 7'h05;
   localparam logic [6:0] ADDR_UV = 7'h0f;
   localparam logic [6:0] ADDR_MEAS = 7'h38;
   // Frame: header byte {rw, addr[6:0]} then one data byte, MSB first
   localparam int HDR_RW_POS = 7;
   localparam logic [4:0] HDR_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam int RANGE_W = 3;
   localparam logic [7:0] TGT_RST = 8'h00;
   localparam logic [2:0] RANGE_RST = 3'h0;
   localparam logic [7:0] UV_RST = 8'h00;
   localparam logic [7:0] MEAS_RST = 8'h00;
   localparam logic [7:0] MEAS_NONE = 8'h00;
   localparam int SYNC_W = 7 + 2 * NUM_CH;
   typedef enum logic [1:0] {
      LEDSC_OFF = 2'b00,
      LEDSC_OPER = 2'b01,
      LEDSC_UV = 2'b10,
      LEDSC_FAIL = 2'b11
   } ledsc_mode_t;
endpackage : ledsc_pkg

//--- logic/ledsc_top.sv
`timescale 1ns/100ps
module ledsc_top (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic SPI_CS_N_I,
   input wire logic SPI_SCLK_I,
   input wire logic SPI_SDI_I,
   output logic SPI_SDO_O,
   output logic SPI_SDO_OE_O,
   input wire logic ENABLE_I,
   input wire logic SUPPLY_POR_OK_I,
   input wire logic OVER_TEMP_I,
   input wire logic GATE_FAULT_I,
   input wire logic [2:0] ABOVE_UPPER_I,
   input wire logic [2:0] BELOW_LOWER_I,
   input wire logic [7:0] MEAS_CODE_I,
   input wire logic MEAS_VALID_I,
   output logic [2:0] GATE_ON_O,
   output logic GATE_SUPPLY_EN_O,
   output logic [23:0] TARGET_CODE_O,
   output logic [2:0] RANGE_SEL_O,
   output logic SUPPLY_ABOVE_UV_O,
   output logic SPI_ERR_O,
   output logic [1:0] MODE_O
);
   localparam int N = ledsc_pkg::NUM_CH;
   localparam int SW = ledsc_pkg::SYNC_W;
   logic [SW-1:0] sync1_r, sync2_r;
   logic sclk_q_r;
   logic cs_s, sclk_s, sdi_s, en_s, por_s, ot_s, gf_s;
   logic [N-1:0] above_s, below_s;
   logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_q_r;
   ledsc_pkg::ledsc_mode_t mode_r, mode_nxt;
   logic oper, spi_on;
   logic [4:0] bit_cnt_r;
   logic [15:0] rx_r;
   logic [7:0] tx_r;
   logic hdr_stb, wr_stb, err_r;
   logic [6:0] hdr_addr;
   logic [7:0] rd_data;
   logic [7:0] tgt_r [N];
   logic [2:0] range_r;
   logic [7:0] uv_thr_r, meas_r;
   logic flag_r;
   logic [N-1:0] gate_r;

   // Two-flop synchronisers for every pin that crosses in
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sclk_q_r <= 1'b0;
         cs_q_r <= 1'b0;
      end else begin
         sync1_r <= {BELOW_LOWER_I, ABOVE_UPPER_I, GATE_FAULT_I, OVER_TEMP_I,
                     SUPPLY_POR_OK_I, ENABLE_I, SPI_SDI_I, SPI_SCLK_I, ~SPI_CS_N_I};
         sync2_r <= sync1_r;
         sclk_q_r <= sclk_s;
         cs_q_r <= cs_s;
      end
   end
   assign {below_s, above_s, gf_s, ot_s, por_s, en_s, sdi_s, sclk_s, cs_s} = sync2_r;
   // Edges come from the second stage only, link clock is oversampled 16x
   assign sclk_rise = sclk_s & ~sclk_q_r;
   assign sclk_fall = ~sclk_s & sclk_q_r;
   assign cs_fall = cs_s & ~cs_q_r;
   assign cs_rise = ~cs_s & cs_q_r;

   // Operating mode; off wins over every other transition
   always_comb begin
      mode_nxt = mode_r;
      if (!en_s || !por_s) begin
         mode_nxt = ledsc_pkg::LEDSC_OFF; // RL13
      end else begin
         case (mode_r)
            ledsc_pkg::LEDSC_OFF: mode_nxt = ledsc_pkg::LEDSC_OPER;
            ledsc_pkg::LEDSC_OPER: begin
               if (ot_s || gf_s) begin
                  mode_nxt = ledsc_pkg::LEDSC_FAIL; // RL1
               end else if (!flag_r) begin
                  mode_nxt = ledsc_pkg::LEDSC_UV; // RL14
               end
            end
            ledsc_pkg::LEDSC_UV: begin
               if (flag_r) begin
                  mode_nxt = ledsc_pkg::LEDSC_OPER;
               end
            end
            ledsc_pkg::LEDSC_FAIL: mode_nxt = ledsc_pkg::LEDSC_FAIL;
            default: mode_nxt = ledsc_pkg::LEDSC_OFF;
         endcase
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         mode_r <= ledsc_pkg::LEDSC_OFF;
      end else begin
         mode_r <= mode_nxt;
      end
   end
   assign oper = (mode_r == ledsc_pkg::LEDSC_OPER);
   // Interface lives in every mode except off
   assign spi_on = (mode_r != ledsc_pkg::LEDSC_OFF); // RL2 RL13

   // Frame bit counter and receive shifter; counts one past a full frame so long frames show
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         bit_cnt_r <= 5'h00;
         rx_r <= 16'h0000;
      end else if (!spi_on || cs_fall) begin
         bit_cnt_r <= 5'h00;
      end else if (cs_s && sclk_rise && bit_cnt_r <= ledsc_pkg::FRAME_BITS) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
         rx_r <= {rx_r[14:0], sdi_s};
      end
   end
   // Header strobe lands on the falling link clock after bit 8; write strobe on chip-select release after bit 16
   assign hdr_stb = spi_on & cs_s & (bit_cnt_r == ledsc_pkg::HDR_BITS) & sclk_fall;
   assign wr_stb = spi_on & cs_rise & (bit_cnt_r == ledsc_pkg::FRAME_BITS)
                   & rx_r[8 + ledsc_pkg::HDR_RW_POS];
   assign hdr_addr = (bit_cnt_r == ledsc_pkg::FRAME_BITS) ? rx_r[14:8] : rx_r[6:0];

   // Read mux; reserved and unmapped bits read zero
   always_comb begin
      case (hdr_addr)
         ledsc_pkg::ADDR_CH1: rd_data = tgt_r[0];
         ledsc_pkg::ADDR_CH2: rd_data = tgt_r[1];
         ledsc_pkg::ADDR_CH3: rd_data = tgt_r[2];
         ledsc_pkg::ADDR_RANGE: rd_data = {5'h00, range_r};
         ledsc_pkg::ADDR_UV: rd_data = uv_thr_r;
         ledsc_pkg::ADDR_MEAS: rd_data = meas_r; // RL4
         default: rd_data = 8'h00;
      endcase
   end

   // Transmit shifter loads after the header, shifts on falling link clock
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         tx_r <= 8'h00;
      end else if (!spi_on || cs_fall) begin
         tx_r <= 8'h00;
      end else if (hdr_stb) begin
         tx_r <= rd_data;
      end else if (cs_s && sclk_fall && bit_cnt_r > ledsc_pkg::HDR_BITS) begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end
   assign SPI_SDO_O = tx_r[7];
   assign SPI_SDO_OE_O = spi_on & cs_s;

   // Error: short or long frame, or write to an unmapped address
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         err_r <= 1'b0;
      end else if (spi_on && cs_rise) begin
         if (bit_cnt_r != ledsc_pkg::FRAME_BITS) begin
            err_r <= 1'b1;
         end else if (wr_stb) begin
            case (rx_r[14:8])
               ledsc_pkg::ADDR_CH1, ledsc_pkg::ADDR_CH2, ledsc_pkg::ADDR_CH3,
               ledsc_pkg::ADDR_RANGE, ledsc_pkg::ADDR_UV,
               ledsc_pkg::ADDR_MEAS: err_r <= err_r; // RL5
               default: err_r <= 1'b1;
            endcase
         end
      end else if (spi_on && cs_fall) begin
         err_r <= 1'b0;
      end
   end
   assign SPI_ERR_O = err_r;

   // Configuration registers, writable in every mode but off
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         range_r <= ledsc_pkg::RANGE_RST;
         uv_thr_r <= ledsc_pkg::UV_RST;
      end else if (wr_stb) begin
         if (rx_r[14:8] == ledsc_pkg::ADDR_RANGE) begin
            range_r <= rx_r[2:0]; // RL8 RL9
         end
         if (rx_r[14:8] == ledsc_pkg::ADDR_UV) begin
            uv_thr_r <= rx_r[7:0]; // RL7
         end
      end
   end

   // Supply code and flag; a zero code means no result, flag keeps its value
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         meas_r <= ledsc_pkg::MEAS_RST;
         flag_r <= 1'b0;
      end else if (MEAS_VALID_I) begin
         meas_r <= MEAS_CODE_I; // RL4
         if (MEAS_CODE_I != ledsc_pkg::MEAS_NONE) begin
            flag_r <= (MEAS_CODE_I > uv_thr_r); // RL6 RL15
         end
      end
   end
   assign SUPPLY_ABOVE_UV_O = flag_r;
   assign GATE_SUPPLY_EN_O = oper; // RL2 RL14
   assign MODE_O = mode_r;
   assign RANGE_SEL_O = range_r; // RL11 RL12

   // Per channel target, hysteretic switch and checks
   for (genvar c = 0; c < N; c++) begin : g_ch
      localparam logic [6:0] CH_ADDR = ledsc_pkg::ADDR_CH1 + 7'(c);
      always_ff @(posedge CORE_CLK_I) begin
         if (!RST_N_I) begin
            tgt_r[c] <= ledsc_pkg::TGT_RST;
         end else if (wr_stb && rx_r[14:8] == CH_ADDR) begin
            tgt_r[c] <= rx_r[7:0]; // RL10
         end
      end
      assign TARGET_CODE_O[8*c +: 8] = tgt_r[c];
      // Above wins if both comparators report at once, safer for the coil
      always_ff @(posedge CORE_CLK_I) begin
         if (!RST_N_I || !oper) begin
            gate_r[c] <= 1'b0;
         end else if (above_s[c]) begin
            gate_r[c] <= 1'b0; // RL3
         end else if (below_s[c]) begin
            gate_r[c] <= 1'b1; // RL3
         end
      end
      // Gating keeps outputs off in the very cycle the mode leaves operation
      assign GATE_ON_O[c] = gate_r[c] & oper; // RL2

      property p_sw_off;
         @(posedge CORE_CLK_I) disable iff (!RST_N_I)
         above_s[c] |=> !GATE_ON_O[c];
      endproperty
      a_sw_off: assert property (p_sw_off) else $error("switch not off above upper"); // RL3

      property p_sw_on;
         @(posedge CORE_CLK_I) disable iff (!RST_N_I)
         (oper && !above_s[c] && below_s[c]) ##1 oper |-> GATE_ON_O[c];
      endproperty
      a_sw_on: assert property (p_sw_on) else $error("switch not on below lower"); // RL3

      property p_tgt_wr;
         @(posedge CORE_CLK_I) disable iff (!RST_N_I)
         (wr_stb && rx_r[14:8] == CH_ADDR) |=> TARGET_CODE_O[8*c +: 8] == $past(rx_r[7:0]);
      endproperty
      a_tgt_wr: assert property (p_tgt_wr) else $error("target write lost"); // RL10
   end

   property p_fail_entry;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (oper && en_s && por_s && (ot_s || gf_s)) |=> mode_r == ledsc_pkg::LEDSC_FAIL;
   endproperty
   a_fail_entry: assert property (p_fail_entry) else $error("fail-silent not entered"); // RL1

   property p_fail_quiet;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (mode_r == ledsc_pkg::LEDSC_FAIL) |-> (GATE_ON_O == 3'h0 && !GATE_SUPPLY_EN_O
                                             && SPI_SDO_OE_O == cs_s);
   endproperty
   a_fail_quiet: assert property (p_fail_quiet) else $error("fail-silent outputs wrong"); // RL2

   property p_meas_rd;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (hdr_stb && hdr_addr == ledsc_pkg::ADDR_MEAS && !MEAS_VALID_I) |=> tx_r == meas_r;
   endproperty
   a_meas_rd: assert property (p_meas_rd) else $error("supply code read wrong"); // RL4

   property p_meas_noerr;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (wr_stb && rx_r[14:8] == ledsc_pkg::ADDR_MEAS) |=> SPI_ERR_O == $past(SPI_ERR_O);
   endproperty
   a_meas_noerr: assert property (p_meas_noerr) else $error("error on supply code write"); // RL5

   property p_flag;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (MEAS_VALID_I && MEAS_CODE_I != 8'h00)
      |=> SUPPLY_ABOVE_UV_O == ($past(MEAS_CODE_I) > $past(uv_thr_r));
   endproperty
   a_flag: assert property (p_flag) else $error("undervoltage flag wrong"); // RL6 RL15

   property p_uv_wr;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (wr_stb && rx_r[14:8] == ledsc_pkg::ADDR_UV) |=> uv_thr_r == $past(rx_r[7:0]);
   endproperty
   a_uv_wr: assert property (p_uv_wr) else $error("threshold write lost"); // RL7

   property p_range_wr;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (wr_stb && rx_r[14:8] == ledsc_pkg::ADDR_RANGE) |=> RANGE_SEL_O == $past(rx_r[2:0]);
   endproperty
   a_range_wr: assert property (p_range_wr) else $error("range write lost"); // RL8

   property p_off;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (!en_s || !por_s) |=> (mode_r == ledsc_pkg::LEDSC_OFF) ##1 !SPI_SDO_OE_O;
   endproperty
   a_off: assert property (p_off) else $error("off mode not entered"); // RL13

   property p_uv_entry;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (oper && en_s && por_s && !ot_s && !gf_s && !flag_r)
      |=> (mode_r == ledsc_pkg::LEDSC_UV && GATE_ON_O == 3'h0);
   endproperty
   a_uv_entry: assert property (p_uv_entry) else $error("undervoltage mode not entered"); // RL14
endmodule : ledsc_top

//--- test/ledsc_spi_host.sv
`timescale 1ns/100ps
// Behavioural microcontroller on the serial side, mode 0, clock parked low between frames
module ledsc_spi_host (
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdi_o
);
   // Idle levels at time zero
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // One frame of nbits, MSB first; data byte captured on rises 9..16
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk_i);
      #1;
      cs_n_o = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      for (int i = 0; i < nbits; i++) begin
         sdi_o = (i < 16) ? tx[15 - i] : 1'b0;
         repeat (8) @(posedge clk_i);
         #1;
         rx = (i >= 8) ? {rx[6:0], sdo_i} : rx;
         sclk_o = 1'b1;
         repeat (8) @(posedge clk_i);
         #1;
         sclk_o = 1'b0;
      end
      repeat (8) @(posedge clk_i);
      #1;
      cs_n_o = 1'b1;
      // Released line is inverted so a stale bit never reads as fresh data
      sdi_o = ~sdi_o;
      repeat (8) @(posedge clk_i);
      #1;
   endtask : xfer
endmodule : ledsc_spi_host

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, en, por_ok, ot, gf, mv, sup_en, above_uv;
   logic spi_err;
   logic [2:0] above, below, gate_on, range_sel;
   logic [7:0] meas, rd;
   logic [23:0] tgt;
   logic [1:0] mode;
   int err_count = 0;
   int checks_done = 0;
   int oe_cnt = 0;

   ledsc_top ledsc_top_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .SPI_CS_N_I(cs_n),
      .SPI_SCLK_I(sclk), .SPI_SDI_I(sdi), .SPI_SDO_O(sdo), .SPI_SDO_OE_O(sdo_oe),
      .ENABLE_I(en), .SUPPLY_POR_OK_I(por_ok), .OVER_TEMP_I(ot), .GATE_FAULT_I(gf),
      .ABOVE_UPPER_I(above), .BELOW_LOWER_I(below), .MEAS_CODE_I(meas), .MEAS_VALID_I(mv),
      .GATE_ON_O(gate_on), .GATE_SUPPLY_EN_O(sup_en), .TARGET_CODE_O(tgt),
      .RANGE_SEL_O(range_sel), .SUPPLY_ABOVE_UV_O(above_uv), .SPI_ERR_O(spi_err),
      .MODE_O(mode));
   ledsc_spi_host ledsc_spi_host_inst (.clk_i(clk), .sdo_i(sdo), .cs_n_o(cs_n),
      .sclk_o(sclk), .sdi_o(sdi));

   // Counts cycles with the data-out driver on, to see it idle in off mode
   always @(posedge clk) begin
      if (sdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
   end

   // 250 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic conclude();
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      ledsc_spi_host_inst.xfer({1'b1, a, d}, 16, rd);
   endtask : wr
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      ledsc_spi_host_inst.xfer({1'b0, a, 8'h00}, 16, rd);
      chk({16'h0000, rd}, {16'h0000, exp}, "read data");
   endtask : rd_chk
   // Bounded wait; a hang is counted and ends the run
   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 60 && mode !== m; i++) cyc(1);
      chk({22'h00_0000, mode}, {22'h00_0000, m}, "mode");
      if (mode !== m) conclude();
   endtask : wait_mode
   task automatic pulse_meas(input logic [7:0] c);
      meas = c;
      mv = 1'b1;
      cyc(1);
      mv = 1'b0;
      cyc(2);
   endtask : pulse_meas

   // Main sequence; every input driven 1 ns after a rising edge
   initial begin
      rst_n = 1'b0;
      en = 1'b0;
      por_ok = 1'b0;
      ot = 1'b0;
      gf = 1'b0;
      above = 3'h0;
      below = 3'h0;
      meas = 8'h00;
      mv = 1'b0;
      cyc(3);
      rst_n = 1'b1;
      cyc(1);
      chk(tgt, 24'h00_0000, "target reset");
      wr(ledsc_pkg::ADDR_CH1, 8'h33);
      chk(tgt, 24'h00_0000, "write in off mode");
      chk({23'h00_0000, oe_cnt == 0}, 24'h00_0001, "sdo driven in off");
      en = 1'b1;
      por_ok = 1'b1;
      wait_mode(ledsc_pkg::LEDSC_UV);
      pulse_meas(8'h80);
      chk({23'h00_0000, above_uv}, 24'h00_0001, "flag above");
      wait_mode(ledsc_pkg::LEDSC_OPER);
      chk({23'h00_0000, sup_en}, 24'h00_0001, "gate supply off in operation");
      for (int i = 0; i < 3; i++) wr(ledsc_pkg::ADDR_CH1 + 7'(i), 8'h5a + 8'(i));
      chk(tgt, 24'h5c_5b5a, "targets");
      for (int i = 0; i < 3; i++) rd_chk(ledsc_pkg::ADDR_CH1 + 7'(i), 8'h5a + 8'(i));
      chk({23'h00_0000, oe_cnt > 0}, 24'h00_0001, "sdo never driven");
      // Fine range on channels 1 and 3, reserved bits kept clear
      wr(ledsc_pkg::ADDR_RANGE, 8'h05);
      chk({21'h00_0000, range_sel}, 24'h00_0005, "range");
      rd_chk(ledsc_pkg::ADDR_RANGE, 8'h05);
      rd_chk(ledsc_pkg::ADDR_MEAS, 8'h80);
      wr(ledsc_pkg::ADDR_MEAS, 8'h12);
      chk({23'h00_0000, spi_err}, 24'h00_0000, "err after meas write");
      rd_chk(ledsc_pkg::ADDR_MEAS, 8'h80);
      // Unmapped write shows the error flag is alive
      wr(7'h10, 8'h01);
      chk({23'h00_0000, spi_err}, 24'h00_0001, "err unmapped");
      rd_chk(7'h10, 8'h00);
      chk({23'h00_0000, spi_err}, 24'h00_0000, "err on unmapped read");
      // Short and long frames must neither write nor pass silently
      ledsc_spi_host_inst.xfer({1'b1, ledsc_pkg::ADDR_CH3, 8'h77}, 8, rd);
      chk({23'h00_0000, spi_err}, 24'h00_0001, "err short frame");
      ledsc_spi_host_inst.xfer({1'b1, ledsc_pkg::ADDR_CH3, 8'h77}, 17, rd);
      chk({23'h00_0000, spi_err}, 24'h00_0001, "err long frame");
      chk(tgt, 24'h5c_5b5a, "bad frame wrote");
      wr(ledsc_pkg::ADDR_UV, 8'h90);
      rd_chk(ledsc_pkg::ADDR_UV, 8'h90);
      below = 3'h7;
      cyc(4);
      chk({21'h00_0000, gate_on}, 24'h00_0007, "switch on");
      // Code equal to threshold is not above it
      pulse_meas(8'h90);
      chk({23'h00_0000, above_uv}, 24'h00_0000, "flag at threshold");
      wait_mode(ledsc_pkg::LEDSC_UV);
      chk({20'h0_0000, gate_on, sup_en}, 24'h00_0000, "uv outputs");
      pulse_meas(8'h91);
      chk({23'h00_0000, above_uv}, 24'h00_0001, "flag recovers");
      wait_mode(ledsc_pkg::LEDSC_OPER);
      pulse_meas(8'h00);
      rd_chk(ledsc_pkg::ADDR_MEAS, 8'h00);
      below = 3'h0;
      above = 3'h2;
      cyc(4);
      chk({21'h00_0000, gate_on}, 24'h00_0005, "switch off ch2");
      above = 3'h7;
      below = 3'h7;
      cyc(4);
      chk({21'h00_0000, gate_on}, 24'h00_0000, "upper wins");
      above = 3'h0;
      cyc(4);
      ot = 1'b1;
      wait_mode(ledsc_pkg::LEDSC_FAIL);
      chk({20'h0_0000, gate_on, sup_en}, 24'h00_0000, "fail outputs");
      rd_chk(ledsc_pkg::ADDR_CH2, 8'h5b);
      wr(ledsc_pkg::ADDR_CH1, 8'h21);
      chk(tgt, 24'h5c_5b21, "write in fail");
      ot = 1'b0;
      en = 1'b0;
      wait_mode(ledsc_pkg::LEDSC_OFF);
      wr(ledsc_pkg::ADDR_CH1, 8'h44);
      chk(tgt, 24'h5c_5b21, "write in off");
      en = 1'b1;
      pulse_meas(8'ha0);
      wait_mode(ledsc_pkg::LEDSC_OPER);
      gf = 1'b1;
      wait_mode(ledsc_pkg::LEDSC_FAIL);
      gf = 1'b0;
      por_ok = 1'b0;
      wait_mode(ledsc_pkg::LEDSC_OFF);
      conclude();
   end
endmodule : tb_top
